// *** hw/pio_host.sv ***
// host-side programmed-I/O cycle engine driving the card pins
`timescale 1ns/1ps
`default_nettype none
module pio_host
(
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // configuration
  input  wire logic [pio_pkg::MODE_W-1:0] mode_i,
  // user request
  input  wire logic                       req_valid_i,
  input  wire logic                       req_write_i,
  input  wire logic                       req_byte_i,
  input  wire logic                       req_attr_i,
  input  wire logic [2:0]                 req_addr_i,
  input  wire logic [15:0]                req_wdata_i,
  output logic                            req_ready_o,
  // user answer
  output logic                            rsp_valid_o,
  output logic [15:0]                     rsp_rdata_o,
  output logic                            rsp_timeout_o,
  output logic                            rsp_wide_o,
  // card pins
  output logic                            io_read_strobe_n_o,
  output logic                            io_write_strobe_n_o,
  output logic                            attribute_space_select_n_o,
  output logic                            low_byte_card_select_n_o,
  output logic                            high_byte_card_select_n_o,
  output logic [2:0]                      host_address_lines_o,
  output logic [15:0]                     host_data_lines_o,
  output logic                            host_data_lines_oe_n_o,
  input  wire logic [15:0]                host_data_lines_i,
  input  wire logic                       io_ready_i,
  input  wire logic                       sel16_n_i
);
  logic [pio_pkg::CNT_W-1:0] active_cyc;
  logic [pio_pkg::CNT_W-1:0] recov_cyc;
  logic [pio_pkg::CNT_W-1:0] max_wait;
  logic                      wait_ok;
  logic                      sel16_ok;
  logic                      wr_q;
  logic                      byte_q;
  logic [pio_pkg::MODE_W-1:0] mode_q;
  pio_pkg::pio_state_e       st_q;
  logic [pio_pkg::CNT_W-1:0] cnt_q;
  logic [pio_pkg::CNT_W-1:0] wcnt_q;
  logic [1:0]                rdy_sync_q;
  logic [1:0]                s16_sync_q;
  logic [15:0]               d_sync0_q;
  logic [15:0]               d_sync1_q;
  logic                      rdy;
  logic                      strobe_on;
  // =====================================================================
  // timing decode, mode latched per cycle so a change mid-cycle is harmless
  // =====================================================================
  pio_timing u_timing
  (
    .mode_i       (mode_q),
    .byte_i       (byte_q),
    .active_cyc_o (active_cyc),
    .recov_cyc_o  (recov_cyc),
    .wait_ok_o    (wait_ok),
    .sel16_ok_o   (sel16_ok),
    .max_wait_o   (max_wait)
  );
  // =====================================================================
  // pin synchronisers
  // =====================================================================
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdy_sync_q <= 2'h3;
      s16_sync_q <= 2'h3;
      d_sync0_q  <= 16'h0000;
      d_sync1_q  <= 16'h0000;
    end
    else
    begin
      rdy_sync_q <= {rdy_sync_q[0], io_ready_i};
      s16_sync_q <= {s16_sync_q[0], sel16_n_i};
      d_sync0_q  <= host_data_lines_i;
      d_sync1_q  <= d_sync0_q;
    end
  end
  // no wait support in fast modes, so ready is treated as high
  assign rdy = rdy_sync_q[1] || !wait_ok;
  assign strobe_on = (st_q == pio_pkg::ST_ACTIVE) || (st_q == pio_pkg::ST_WAIT);
  // =====================================================================
  // cycle sequencer
  // =====================================================================
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q   <= pio_pkg::ST_IDLE;
      cnt_q  <= '0;
      wcnt_q <= '0;
      wr_q   <= 1'b0;
      byte_q <= 1'b0;
      mode_q <= '0;
    end
    else
    begin
      case (st_q)
        pio_pkg::ST_IDLE:
        begin
          if (req_valid_i)
          begin
            wr_q   <= req_write_i;
            byte_q <= req_byte_i;
            mode_q <= mode_i;
            cnt_q  <= pio_pkg::SETUP_CYC;
            st_q   <= pio_pkg::ST_SETUP;
          end
        end
        pio_pkg::ST_SETUP:
        begin
          if (cnt_q <= 1)
          begin
            cnt_q  <= '0;
            wcnt_q <= '0;
            st_q   <= pio_pkg::ST_ACTIVE;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        pio_pkg::ST_ACTIVE:
        begin
          cnt_q <= cnt_q + 1'b1;
          // sample only once the sample point plus sync delay is past
          if (cnt_q >= pio_pkg::SAMPLE_CYC + 2 && !rdy)
          begin
            st_q <= pio_pkg::ST_WAIT;
          end
          else if (cnt_q + 1'b1 >= active_cyc && cnt_q >= pio_pkg::SAMPLE_CYC + 2)
          begin
            cnt_q <= pio_pkg::HOLD_CYC;
            st_q  <= pio_pkg::ST_HOLD;
          end
        end
        pio_pkg::ST_WAIT:
        begin
          cnt_q  <= cnt_q + 1'b1;
          wcnt_q <= wcnt_q + 1'b1;
          // ready back: release once minimum width is also met
          if ((rdy && cnt_q + 1'b1 >= active_cyc) || wcnt_q >= max_wait + 4)
          begin
            cnt_q <= pio_pkg::HOLD_CYC;
            st_q  <= pio_pkg::ST_HOLD;
          end
        end
        pio_pkg::ST_HOLD:
        begin
          if (cnt_q <= 1)
          begin
            cnt_q <= recov_cyc;
            st_q  <= pio_pkg::ST_RECOV;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        pio_pkg::ST_RECOV:
        begin
          if (cnt_q <= 1)
          begin
            st_q <= pio_pkg::ST_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default:
        begin
          st_q <= pio_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // =====================================================================
  // pins: address, selects and data stay through setup to hold end
  // =====================================================================
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      io_read_strobe_n_o         <= 1'b1;
      io_write_strobe_n_o        <= 1'b1;
      attribute_space_select_n_o <= 1'b1;
      low_byte_card_select_n_o   <= 1'b1;
      high_byte_card_select_n_o  <= 1'b1;
      host_address_lines_o       <= 3'h0;
      host_data_lines_o          <= 16'h0000;
      host_data_lines_oe_n_o     <= 1'b1;
    end
    else if (st_q == pio_pkg::ST_IDLE && req_valid_i)
    begin
      attribute_space_select_n_o <= !req_attr_i;
      low_byte_card_select_n_o   <= 1'b0;
      high_byte_card_select_n_o  <= req_byte_i;
      host_address_lines_o       <= req_addr_i;
      host_data_lines_o          <= req_wdata_i;
      host_data_lines_oe_n_o     <= !req_write_i;
    end
    else if (st_q == pio_pkg::ST_SETUP && cnt_q <= 1)
    begin
      io_read_strobe_n_o  <= wr_q;
      io_write_strobe_n_o <= !wr_q;
    end
    else if (st_q == pio_pkg::ST_HOLD && cnt_q == pio_pkg::HOLD_CYC)
    begin
      io_read_strobe_n_o  <= 1'b1;
      io_write_strobe_n_o <= 1'b1;
    end
    else if (st_q == pio_pkg::ST_RECOV && cnt_q == recov_cyc)
    begin
      attribute_space_select_n_o <= 1'b1;
      low_byte_card_select_n_o   <= 1'b1;
      high_byte_card_select_n_o  <= 1'b1;
      host_data_lines_oe_n_o     <= 1'b1;
    end
  end
  // =====================================================================
  // answer to the user
  // =====================================================================
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rsp_valid_o   <= 1'b0;
      rsp_rdata_o   <= 16'h0000;
      rsp_timeout_o <= 1'b0;
      rsp_wide_o    <= 1'b0;
      req_ready_o   <= 1'b0;
    end
    else
    begin
      req_ready_o <= (st_q == pio_pkg::ST_IDLE) && !req_valid_i;
      rsp_valid_o <= 1'b0;
      if (strobe_on && ((st_q == pio_pkg::ST_ACTIVE && cnt_q + 1'b1 >= active_cyc &&
          cnt_q >= pio_pkg::SAMPLE_CYC + 2 && rdy) || (st_q == pio_pkg::ST_WAIT &&
          ((rdy && cnt_q + 1'b1 >= active_cyc) || wcnt_q >= max_wait + 4))))
      begin
        // data sampled with strobe still low
        rsp_valid_o   <= 1'b1;
        rsp_rdata_o   <= wr_q ? 16'h0000 : (byte_q ? {8'h00, d_sync1_q[7:0]} : d_sync1_q);
        rsp_timeout_o <= (st_q == pio_pkg::ST_WAIT) && !rdy;
        rsp_wide_o    <= sel16_ok && !s16_sync_q[1];
      end
    end
  end
  // =====================================================================
  // checks
  // =====================================================================
  strobe_exclusive_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !(!io_read_strobe_n_o && !io_write_strobe_n_o)) else $error("both strobes low");
  active_width_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(io_read_strobe_n_o & io_write_strobe_n_o) |->
    !(io_read_strobe_n_o & io_write_strobe_n_o) [*3]) else $error("strobe too short");
  recovery_gap_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(io_read_strobe_n_o & io_write_strobe_n_o) |->
    (io_read_strobe_n_o & io_write_strobe_n_o) [*2]) else $error("recovery too short");
  wait_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_q == pio_pkg::ST_WAIT && !rdy && wcnt_q < max_wait) |=> strobe_on)
    else $error("strobe released during wait");
  // checks the sequencer itself, independent of the decoded width
  byte_stretch_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_q == pio_pkg::ST_ACTIVE && byte_q && mode_q <= pio_pkg::MODE_IDE2 &&
    cnt_q + 1'b1 < pio_pkg::BYTE_CYC) |=> strobe_on) else $error("byte strobe not stretched");
  total_cycle_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    st_q == pio_pkg::ST_RECOV |-> 8'(active_cyc) + 8'(recov_cyc) >=
    8'(pio_pkg::ns_to_cyc(pio_pkg::MIN_TOTAL_NS[0])) || mode_q != 4'h0)
    else $error("cycle too short");
  select_setup_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(io_read_strobe_n_o & io_write_strobe_n_o) |-> $past(!low_byte_card_select_n_o))
    else $error("select not ahead of strobe");
  no_wait_fast_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !wait_ok |-> st_q != pio_pkg::ST_WAIT) else $error("wait in fast mode");
  read_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) rsp_valid_o && !wr_q);
  write_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) rsp_valid_o && wr_q);
  wait_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    st_q == pio_pkg::ST_WAIT ##1 st_q == pio_pkg::ST_HOLD);
endmodule
`default_nettype wire

// *** common/pio_pkg.sv ***
// constants and types for the programmed-I/O host cycle engine
// Functional notes
// - host keeps total cycle above mode minimum
// - host holds strobe active at mode minimum
// - byte register strobes stretched to 290 ns in modes 0..2
// - host keeps recovery minimum between strobes
// - cycle equals active plus inactive, lengthen
// - host samples ready 35 ns after strobe
// - ready low: hold strobe until ready high; the host releases it anyway once wcnt_q reaches max_wait + 4
// - no wait insertion in fastest modes
// - read strobe may end at ready rise
// - write strobe may end at ready rise
// - register chosen by selects and address
package pio_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // wide enough that the longest wait limit plus margin is reachable
  localparam int CNT_W         = 7;
  localparam int NUM_MODES     = 11;
  localparam int MODE_W        = 4;
  // modes 0..6 ide pio, 7..10 io classes 250/120/100/80 ns
  localparam logic [MODE_W-1:0] MODE_IO250 = 4'h7;
  localparam logic [MODE_W-1:0] MODE_IO120 = 4'h8;
  localparam logic [MODE_W-1:0] MODE_IO100 = 4'h9;
  localparam logic [MODE_W-1:0] MODE_IO80  = 4'ha;
  localparam logic [MODE_W-1:0] MODE_IDE2  = 4'h2;
  localparam logic [MODE_W-1:0] MODE_IDE4  = 4'h4;
  localparam int BYTE_ACTIVE_NS  = 290;
  localparam int WAIT_SAMPLE_NS  = 35;
  localparam int IDE_MAX_WAIT_NS = 1250;
  localparam int IO_MAX_WAIT_NS  = 350;
  localparam int SETUP_NS        = 70;
  localparam int HOLD_NS         = 30;
  typedef int ns_tbl_t [NUM_MODES];
  localparam ns_tbl_t MIN_TOTAL_NS  = '{600, 383, 240, 180, 120, 100, 80, 250, 120, 100, 80};
  localparam ns_tbl_t MIN_ACTIVE_NS = '{165, 125, 100, 80, 70, 65, 55, 165, 70, 65, 65};
  localparam ns_tbl_t MIN_RECOV_NS  = '{0, 0, 0, 70, 25, 25, 20, 30, 15, 15, 15};
  // least times round up
  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction
  localparam logic [CNT_W-1:0] SAMPLE_CYC = ns_to_cyc(WAIT_SAMPLE_NS);
  localparam logic [CNT_W-1:0] SETUP_CYC  = ns_to_cyc(SETUP_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC   = ns_to_cyc(HOLD_NS);
  localparam logic [CNT_W-1:0] BYTE_CYC   = ns_to_cyc(BYTE_ACTIVE_NS);
  // longest wait rounds down, plus sync delay margin
  localparam logic [CNT_W-1:0] IDE_WAIT_CYC = CNT_W'(IDE_MAX_WAIT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] IO_WAIT_CYC  = CNT_W'(IO_MAX_WAIT_NS / CLK_PERIOD_NS);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_WAIT   = 3'b011,
    ST_HOLD   = 3'b100,
    ST_RECOV  = 3'b101
  } pio_state_e;
endpackage

// *** hw/pio_timing.sv ***
// mode-to-cycle-count decoder for the host cycle engine
`timescale 1ns/1ps
`default_nettype none
module pio_timing
(
  // selection
  input  wire logic [pio_pkg::MODE_W-1:0] mode_i,
  input  wire logic                       byte_i,
  // derived counts
  output logic [pio_pkg::CNT_W-1:0]       active_cyc_o,
  output logic [pio_pkg::CNT_W-1:0]       recov_cyc_o,
  output logic                            wait_ok_o,
  output logic                            sel16_ok_o,
  output logic [pio_pkg::CNT_W-1:0]       max_wait_o
);
  logic [pio_pkg::CNT_W-1:0] act;
  logic [pio_pkg::CNT_W-1:0] rec;
  logic [pio_pkg::CNT_W-1:0] tot;
  logic [pio_pkg::CNT_W-1:0] fill;
  always_comb
  begin
    act  = pio_pkg::ns_to_cyc(pio_pkg::MIN_ACTIVE_NS[0]);
    rec  = pio_pkg::ns_to_cyc(pio_pkg::MIN_RECOV_NS[0]);
    tot  = pio_pkg::ns_to_cyc(pio_pkg::MIN_TOTAL_NS[0]);
    for (int m = 0; m < pio_pkg::NUM_MODES; m++)
    begin
      if (mode_i == pio_pkg::MODE_W'(m))
      begin
        act = pio_pkg::ns_to_cyc(pio_pkg::MIN_ACTIVE_NS[m]);
        rec = pio_pkg::ns_to_cyc(pio_pkg::MIN_RECOV_NS[m]);
        tot = pio_pkg::ns_to_cyc(pio_pkg::MIN_TOTAL_NS[m]);
      end
    end
    if (byte_i && mode_i <= pio_pkg::MODE_IDE2)
    begin
      act = pio_pkg::BYTE_CYC;
    end
    // stretch recovery so the whole cycle meets its minimum
    fill = (tot > act) ? tot - act : '0;
    recov_cyc_o  = (fill > rec) ? fill : rec;
    active_cyc_o = act;
  end
  assign wait_ok_o  = (mode_i <= pio_pkg::MODE_IDE4) || (mode_i == pio_pkg::MODE_IO250) ||
                      (mode_i == pio_pkg::MODE_IO120) || (mode_i == pio_pkg::MODE_IO100);
  assign sel16_ok_o = (mode_i <= pio_pkg::MODE_IDE2);
  assign max_wait_o = (mode_i <= pio_pkg::MODE_IDE4) ? pio_pkg::IDE_WAIT_CYC : pio_pkg::IO_WAIT_CYC;
endmodule
`default_nettype wire

// *** dv/pio_card_model.sv ***
// behavioural card model answering the host cycle engine pins
`timescale 1ns/1ps
`default_nettype none
module pio_card_model
(
  // host pins
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        attr_n_i,
  input  wire logic        ce_lo_n_i,
  input  wire logic        ce_hi_n_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [15:0] hd_i,
  input  wire logic        hd_oe_n_i,
  // card answers
  output logic [15:0]      hd_o,
  output logic             ready_o,
  output logic             sel16_n_o
);
  int          wait_cyc  = 0;
  logic        wide_en   = 1'b0;
  logic        last_attr = 1'b1;
  logic [15:0] mem [8];
  initial
  begin
    foreach (mem[i])
      mem[i] = 16'h0000;
    hd_o    = 16'h0000;
    ready_o = 1'b1;
  end
  // 16-bit select follows the low-byte card select; bench decides if it is shown
  assign sel16_n_o = ce_lo_n_i | ~wide_en;
  // data well before strobe end; upper byte is junk on byte reads
  always @(negedge rd_n_i)
  begin
    #15;
    if (!ce_lo_n_i)
      hd_o = {ce_hi_n_i ? ~mem[addr_i][15:8] : mem[addr_i][15:8],
              mem[addr_i][7:0]};
  end
  // released bus shows the inverse so stale data cannot pass
  always @(posedge rd_n_i)
  begin
    #5;
    hd_o = ~hd_o;
  end
  always @(posedge wr_n_i)
  begin
    if (!ce_lo_n_i && !hd_oe_n_i)
      mem[addr_i][7:0] = hd_i[7:0];
    if (!ce_hi_n_i && !hd_oe_n_i)
      mem[addr_i][15:8] = hd_i[15:8];
  end
  // wait only when the bench asks; never asked in the fastest modes
  always @(negedge (rd_n_i & wr_n_i))
  begin
    last_attr = attr_n_i;
    if (wait_cyc > 0)
    begin
      #10;
      ready_o = 1'b0;
      #(wait_cyc * 20);
      ready_o = 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the host cycle engine against a card model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                       clk_i       = 1'b0;
  logic                       rst_n_i     = 1'b0;
  logic [pio_pkg::MODE_W-1:0] mode_i      = '0;
  logic                       req_valid_i = 1'b0;
  logic                       req_write_i = 1'b0;
  logic                       req_byte_i  = 1'b0;
  logic                       req_attr_i  = 1'b0;
  logic [2:0]                 req_addr_i  = 3'h0;
  logic [15:0]                req_wdata_i = 16'h0000;
  wire logic                  req_ready_o, rsp_valid_o, rsp_timeout_o, rsp_wide_o;
  wire logic [15:0]           rsp_rdata_o, hd_o, hd_i;
  wire logic                  rd_n, wr_n, attr_n, ce_lo_n, ce_hi_n, hd_oe_n, ready, sel16_n;
  wire logic [2:0]            addr;
  wire logic                  strb_n = rd_n & wr_n;
  int          n_errors = 0;
  int          check_count = 0;
  int          act_w, rec_w, tot_w, lo_c, hi_c, per_c, cyc;
  logic [15:0] rd_q;
  logic        to_q, wide_q;

  pio_host DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_byte_i(req_byte_i),
    .req_attr_i(req_attr_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .rsp_timeout_o(rsp_timeout_o), .rsp_wide_o(rsp_wide_o),
    .io_read_strobe_n_o(rd_n), .io_write_strobe_n_o(wr_n),
    .attribute_space_select_n_o(attr_n), .low_byte_card_select_n_o(ce_lo_n),
    .high_byte_card_select_n_o(ce_hi_n), .host_address_lines_o(addr),
    .host_data_lines_o(hd_o), .host_data_lines_oe_n_o(hd_oe_n),
    .host_data_lines_i(hd_i), .io_ready_i(ready), .sel16_n_i(sel16_n));
  pio_card_model card (.rd_n_i(rd_n), .wr_n_i(wr_n), .attr_n_i(attr_n), .ce_lo_n_i(ce_lo_n),
    .ce_hi_n_i(ce_hi_n), .addr_i(addr), .hd_i(hd_o), .hd_oe_n_i(hd_oe_n), .hd_o(hd_i),
    .ready_o(ready), .sel16_n_o(sel16_n));

  always #10 clk_i = ~clk_i;

  // strobe widths measured on the falling clock edge, where pins are settled
  always @(negedge clk_i)
  begin
    cyc = cyc + 1;
    per_c = per_c + 1;
    if (strb_n === 1'b0)
    begin
      lo_c = lo_c + 1;
      if (lo_c == 1)
      begin
        rec_w = hi_c;
        tot_w = per_c;
        per_c = 0;
      end
      hi_c = 0;
    end
    else
    begin
      if (lo_c > 0)
        act_w = lo_c;
      lo_c = 0;
      hi_c = hi_c + 1;
    end
    if (cyc > 20000)
    begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_ge(input string what, input int lo, input int got);
    check_count = check_count + 1;
    if (got < lo)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] %s expected at least %0d seen %0d", what, lo, got);
    end
  endtask

  // one transfer: waits for idle, request held until the selects show it was taken
  task automatic op(input logic wr, input logic byt, input logic at, input logic [2:0] a,
                    input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    // selects of the last cycle still stand until recovery, so wait for idle first
    while (req_ready_o !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
    req_write_i = wr;
    req_byte_i  = byt;
    req_attr_i  = at;
    req_addr_i  = a;
    req_wdata_i = wd;
    req_valid_i = 1'b1;
    n = 0;
    while (ce_lo_n !== 1'b0 && n < 300)
    begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
    req_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
    chk("rsp_valid", 16'h0001, 16'(rsp_valid_o));
    rd_q   = rsp_rdata_o;
    to_q   = rsp_timeout_o;
    wide_q = rsp_wide_o;
  endtask

  task automatic t_reset();
    repeat (20) @(posedge clk_i);
    chk("strobes in reset", 16'h0003, {14'h0, rd_n, wr_n});
    chk("selects in reset", 16'h0007, {13'h0, attr_n, ce_lo_n, ce_hi_n});
    chk("oe_n in reset", 16'h0001, 16'(hd_oe_n));
    #1;
    rst_n_i = 1'b1;
    @(posedge clk_i);
    #1;
    chk("req_ready after reset", 16'h0001, 16'(req_ready_o));
  endtask

  // every mode back to back: widths, recovery, period, wide select
  task automatic t_modes();
    for (int m = 0; m < pio_pkg::NUM_MODES; m++)
    begin
      mode_i = pio_pkg::MODE_W'(m);
      card.wide_en = 1'b1;
      op(1'b1, 1'b0, 1'b0, 3'(m), 16'ha500 | 16'(m));
      chk("write rdata", 16'h0000, rd_q);
      op(1'b0, 1'b0, 1'b0, 3'(m), 16'h0000);
      chk("mode rdata", 16'ha500 | 16'(m), rd_q);
      chk("mode wide", 16'(m <= 2), 16'(wide_q));
      repeat (3) @(posedge clk_i);
      #1;
      chk_ge("active ns", pio_pkg::MIN_ACTIVE_NS[m], act_w * 20);
      chk_ge("recovery ns", pio_pkg::MIN_RECOV_NS[m], rec_w * 20);
      chk_ge("total ns", pio_pkg::MIN_TOTAL_NS[m], tot_w * 20);
    end
    card.wide_en = 1'b0;
  endtask

  // byte transfers stretch the strobe and touch the low byte only
  task automatic t_byte();
    mode_i = 4'h0;
    op(1'b1, 1'b1, 1'b1, 3'h5, 16'h12ab);
    chk("attr select", 16'h0000, 16'(card.last_attr));
    repeat (3) @(posedge clk_i);
    #1;
    chk_ge("byte active ns", pio_pkg::BYTE_ACTIVE_NS, act_w * 20);
    op(1'b0, 1'b1, 1'b0, 3'h5, 16'h0000);
    chk("byte rdata", 16'h00ab, rd_q);
    op(1'b0, 1'b0, 1'b0, 3'h5, 16'h0000);
    chk("word after byte", 16'ha5ab, rd_q);
  endtask

  // waits inside the limits, then one the card holds far too long
  task automatic t_wait();
    mode_i = pio_pkg::MODE_IDE2;
    card.wait_cyc = 12;
    op(1'b1, 1'b0, 1'b0, 3'h1, 16'h3c3c);
    repeat (3) @(posedge clk_i);
    #1;
    chk_ge("write held for wait", 12, act_w);
    op(1'b0, 1'b0, 1'b0, 3'h1, 16'h0000);
    chk("wait rdata", 16'h3c3c, rd_q);
    chk("wait no timeout", 16'h0000, 16'(to_q));
    repeat (3) @(posedge clk_i);
    #1;
    chk_ge("read held for wait", 12, act_w);
    mode_i = pio_pkg::MODE_IO250;
    card.wait_cyc = 8;
    op(1'b0, 1'b0, 1'b0, 3'h1, 16'h0000);
    chk("io wait rdata", 16'h3c3c, rd_q);
    card.wait_cyc = 40;
    op(1'b0, 1'b0, 1'b0, 3'h1, 16'h0000);
    chk("wait timeout", 16'h0001, 16'(to_q));
    card.wait_cyc = 0;
    repeat (60) @(posedge clk_i);
    #1;
    op(1'b0, 1'b0, 1'b0, 3'h1, 16'h0000);
    chk("after timeout", 16'h3c3c, rd_q);
  endtask

  initial
  begin
    act_w = 0;
    rec_w = 0;
    tot_w = 0;
    lo_c  = 0;
    hi_c  = 0;
    per_c = 0;
    cyc   = 0;
    t_reset();
    t_modes();
    t_byte();
    t_wait();
    end_sim();
  end
endmodule
`default_nettype wire
